// ### standby_params.svh
// Offsets, bit positions and reset values of the standby mode controller.
`ifndef STANDBY_PARAMS_SVH
`define STANDBY_PARAMS_SVH
`define SMC_OFF_POWER 8'h00
`define SMC_OFF_SLOW 8'h04
`define SMC_OFF_OSC 8'h08
`define SMC_OFF_MULTI 8'h0C
`define SMC_OFF_WDOG 8'h10
`define SMC_PWR_HALT 0
`define SMC_PWR_STOP 1
`define SMC_PWR_XTAL 2
`define SMC_PWR_UPPER 5'h1F
`define SMC_SLOW_MIDOFF 0
`define SMC_SLOW_LOWSEL 1
`define SMC_OSC_MAIN 0
`define SMC_OSC_MIDOFF 1
`define SMC_OSC_SUB 2
`define SMC_OSC_SEL_LO 4
`define SMC_OSC_SEL_HI 5
`define SMC_MULTI_EN 0
`define SMC_WDOG_SLEEPEN 3
`define SMC_WDOG_HOLDRUN 4
`define SMC_WDOG_RUN 5
`define SMC_WDOG_CAUSE 7
`define SMC_RST_SLOW 8'h00
`define SMC_RST_OSC 8'h00
`define SMC_RST_MULTI 8'h00
`define SMC_RST_WDOG 8'h00
`endif

// ### standby_pkg.sv
// Types shared by the standby mode controller.
`default_nettype none
package standby_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_HALT,
        MODE_HOLD,
        MODE_XHOLD
    } mode_t;
    typedef struct packed {
        logic mainOsc;
        logic subOsc;
        logic lowRc;
        logic midRc;
        logic multiRc;
    } osc_en_t;
endpackage
`default_nettype wire

// ### standby_mode_controller.sv
// Standby mode controller with APB register access.
// Behaviour
// - Unimplemented power register bits 7 to 3 read as one.
// - Stop clear is normal or halt; stop alone hold; both crystal hold.
// - Hold entry stops main, sub, low, medium and multi RC oscillators.
// - Hold entry with low RC selected sets slow bit 0, clears osc bits 4, 5.
// - Hold entry without low RC selected clears osc bits 1, 4 and 5.
// - Leaving hold restarts low or medium RC per current register values.
// - Leaving hold restores main and sub enables; multi RC stays stopped.
// - Crystal hold stops all but subclock; leaves clock registers unchanged.
// - Crystal keep flag is cleared only by a software write or by reset.
// - Wake signals or reset clear the stop flag.
// - Stop flag set forces the halt flag set.
// - Halt flag set suspends CPU instruction execution.
// - Interrupt acceptance or reset clears the halt flag.
// - Pin, supply drop or watchdog cause reset; watchdog sets wdog bit 7.
// - Standby entry clears wdog bit 5 when bit 4 is 0 and bit 3 is 1.
// - During reset only medium RC runs and the CPU is held.
// - In halt oscillators keep state; watchdog may also run low RC.
// - Wake from stop leaves the CPU in halt until an interrupt is taken.
// - In crystal hold the base timer runs on subclock and can wake.
//
// The register addresses and the APB interface to the registers were decided locally.
`include "standby_params.svh"
`default_nettype none
module standby_mode_controller (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic externalClearPin,
    input wire logic supplyDropDetector,
    input wire logic wdogTrip,
    input wire logic wdogLowRcReq,
    input wire logic irqAccept,
    input wire logic baseTimerIrq,
    input wire logic extIrqZero,
    input wire logic extIrqOne,
    input wire logic extIrqTwo,
    input wire logic extIrqFour,
    input wire logic port0Irq,
    output standby_pkg::osc_en_t oscEn,
    output standby_pkg::mode_t mode,
    output logic cpuStopped,
    output logic cpuInReset,
    output logic baseTimerRun
);
    logic [7:0] syncA_q;
    logic [7:0] syncB_q;
    logic halt_q, halt_d;
    logic stop_q, stop_d;
    logic xtal_q, xtal_d;
    logic [7:0] slow_q, slow_d;
    logic [7:0] osc_q, osc_d;
    logic [7:0] multi_q, multi_d;
    logic [7:0] wdog_q, wdog_d;
    logic inReset_q;

    wire logic access = psel & penable & clkEn;
    wire logic hitPwr = paddr == `SMC_OFF_POWER;
    wire logic hitSlow = paddr == `SMC_OFF_SLOW;
    wire logic hitOsc = paddr == `SMC_OFF_OSC;
    wire logic hitMulti = paddr == `SMC_OFF_MULTI;
    wire logic hitWdog = paddr == `SMC_OFF_WDOG;
    wire logic hitAny = hitPwr | hitSlow | hitOsc | hitMulti | hitWdog;
    wire logic wr = access & pwrite & hitAny;
    wire logic wrPwr = wr & hitPwr;
    wire logic sysReset = syncB_q[0] | syncB_q[1] | wdogTrip;
    wire logic extWake = |syncB_q[7:3];
    wire logic btWake = syncB_q[2];
    wire logic wake = extWake | (xtal_q & btWake);
    wire logic enterStandby = wrPwr & (pwdata[`SMC_PWR_HALT] | pwdata[`SMC_PWR_STOP]);
    wire logic holdEntry = wrPwr & pwdata[`SMC_PWR_STOP] & ~pwdata[`SMC_PWR_XTAL];
    wire logic [7:0] pwrRead = {`SMC_PWR_UPPER, xtal_q, stop_q, halt_q};
    wire logic [7:0] rdByte = hitPwr ? pwrRead :
                              hitSlow ? slow_q :
                              hitOsc ? osc_q :
                              hitMulti ? multi_q :
                              hitWdog ? wdog_q : 8'h00;

    assign pready = clkEn;
    assign pslverr = psel & penable & ~hitAny;
    assign prdata = (psel & ~pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;

    always_comb begin
        halt_d = halt_q;
        stop_d = stop_q;
        xtal_d = xtal_q;
        slow_d = slow_q;
        osc_d = osc_q;
        multi_d = multi_q;
        wdog_d = wdog_q;
        if (sysReset) begin
            halt_d = 1'b0;
            stop_d = 1'b0;
            xtal_d = 1'b0;
            slow_d = `SMC_RST_SLOW;
            osc_d = `SMC_RST_OSC;
            multi_d = `SMC_RST_MULTI;
            wdog_d = `SMC_RST_WDOG;
            wdog_d[`SMC_WDOG_CAUSE] = wdogTrip | wdog_q[`SMC_WDOG_CAUSE];
        end else begin
            if (stop_q & wake) begin
                stop_d = 1'b0;
            end
            if (irqAccept & ~stop_q) begin
                halt_d = 1'b0;
            end
            if (wrPwr) begin
                xtal_d = pwdata[`SMC_PWR_XTAL];
                stop_d = pwdata[`SMC_PWR_STOP];
                halt_d = pwdata[`SMC_PWR_HALT] | pwdata[`SMC_PWR_STOP];
            end
            if (wr & hitSlow) begin
                slow_d = pwdata[7:0];
            end
            if (wr & hitOsc) begin
                osc_d = pwdata[7:0];
            end
            if (wr & hitMulti) begin
                multi_d = pwdata[7:0];
            end
            if (wr & hitWdog) begin
                wdog_d = pwdata[7:0];
            end
            if (enterStandby & ~wdog_q[`SMC_WDOG_HOLDRUN] & wdog_q[`SMC_WDOG_SLEEPEN]) begin
                wdog_d[`SMC_WDOG_RUN] = 1'b0;
            end
            if (holdEntry) begin
                osc_d[`SMC_OSC_SEL_LO] = 1'b0;
                osc_d[`SMC_OSC_SEL_HI] = 1'b0;
                multi_d[`SMC_MULTI_EN] = 1'b0;
                if (slow_q[`SMC_SLOW_LOWSEL]) begin
                    slow_d[`SMC_SLOW_MIDOFF] = 1'b1;
                end else begin
                    osc_d[`SMC_OSC_MIDOFF] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            syncA_q <= 8'h00;
            syncB_q <= 8'h00;
            halt_q <= 1'b0;
            stop_q <= 1'b0;
            xtal_q <= 1'b0;
            slow_q <= `SMC_RST_SLOW;
            osc_q <= `SMC_RST_OSC;
            multi_q <= `SMC_RST_MULTI;
            wdog_q <= `SMC_RST_WDOG;
            inReset_q <= 1'b1;
        end else if (clkEn) begin
            syncA_q <= {port0Irq, extIrqFour, extIrqTwo, extIrqOne, extIrqZero,
                        baseTimerIrq, supplyDropDetector, externalClearPin};
            syncB_q <= syncA_q;
            halt_q <= halt_d;
            stop_q <= stop_d;
            xtal_q <= xtal_d;
            slow_q <= slow_d;
            osc_q <= osc_d;
            multi_q <= multi_d;
            wdog_q <= wdog_d;
            inReset_q <= sysReset;
        end
    end

    assign mode = stop_q ? (xtal_q ? standby_pkg::MODE_XHOLD : standby_pkg::MODE_HOLD) :
                  (halt_q ? standby_pkg::MODE_HALT : standby_pkg::MODE_NORMAL);

    standby_pkg::osc_en_t runEn;
    assign runEn.mainOsc = osc_q[`SMC_OSC_MAIN];
    assign runEn.subOsc = osc_q[`SMC_OSC_SUB];
    assign runEn.lowRc = slow_q[`SMC_SLOW_LOWSEL];
    assign runEn.midRc = ~osc_q[`SMC_OSC_MIDOFF] & ~slow_q[`SMC_SLOW_MIDOFF];
    assign runEn.multiRc = multi_q[`SMC_MULTI_EN];

    always_comb begin
        oscEn = runEn;
        baseTimerRun = 1'b1;
        if (inReset_q) begin
            oscEn = '0;
            oscEn.midRc = 1'b1;
            baseTimerRun = 1'b0;
        end else begin
            unique case (mode)
                standby_pkg::MODE_NORMAL: begin
                    oscEn = runEn;
                end
                standby_pkg::MODE_HALT: begin
                    oscEn.lowRc = runEn.lowRc | wdogLowRcReq;
                end
                standby_pkg::MODE_HOLD: begin
                    oscEn = '0;
                    baseTimerRun = 1'b0;
                end
                standby_pkg::MODE_XHOLD: begin
                    oscEn = '0;
                    oscEn.subOsc = runEn.subOsc;
                    baseTimerRun = runEn.subOsc;
                end
            endcase
        end
    end

    assign cpuStopped = halt_q | stop_q | inReset_q;
    assign cpuInReset = inReset_q;

    property p_upper_ones;
        @(posedge clock) disable iff (!rst_n)
        (psel & ~pwrite & hitPwr) |-> prdata[7:3] == 5'h1F;
    endproperty
    a_upper_ones: assert property (p_upper_ones) else $error("Power register upper bits not one.");

    property p_hold_off;
        @(posedge clock) disable iff (!rst_n)
        (mode == standby_pkg::MODE_HOLD & ~inReset_q) |-> (oscEn == '0 && !baseTimerRun);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("Oscillator running in hold.");

    property p_hold_low;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & holdEntry & ~sysReset & slow_q[1]) |=>
            (slow_q[0] && osc_q[5:4] == 2'b00 && mode == standby_pkg::MODE_HOLD);
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("Hold entry low RC effects missing.");

    property p_hold_mid;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & holdEntry & ~sysReset & ~slow_q[1]) |=>
            (!osc_q[1] && osc_q[5:4] == 2'b00 && !multi_q[0]);
    endproperty
    a_hold_mid: assert property (p_hold_mid) else $error("Hold entry medium RC effects missing.");

    property p_xhold_keep;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & wrPwr & pwdata[2] & pwdata[1] & ~sysReset) |=>
            ($stable(osc_q) && $stable(slow_q) && $stable(multi_q) && !oscEn.mainOsc && !oscEn.midRc);
    endproperty
    a_xhold_keep: assert property (p_xhold_keep) else $error("Crystal hold changed clock registers.");

    property p_xtal_sw_only;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & xtal_q & ~wrPwr & ~sysReset) |=> xtal_q;
    endproperty
    a_xtal_sw_only: assert property (p_xtal_sw_only) else $error("Crystal flag cleared by hardware.");

    property p_wake_halt;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & stop_q & wake & ~wrPwr & ~sysReset) |=> (!stop_q && halt_q && cpuStopped);
    endproperty
    a_wake_halt: assert property (p_wake_halt) else $error("Wake did not drop to halt.");

    property p_stop_halt;
        @(posedge clock) disable iff (!rst_n)
        stop_q |-> (halt_q && cpuStopped);
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("Stop flag without halt flag.");

    property p_irq_clear;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & halt_q & ~stop_q & irqAccept & ~wrPwr) |=> !halt_q;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("Interrupt did not clear halt.");

    property p_wdog_cause;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & wdogTrip) |=> (wdog_q[7] && cpuInReset);
    endproperty
    a_wdog_cause: assert property (p_wdog_cause) else $error("Watchdog cause bit not set.");

    property p_reset_osc;
        @(posedge clock) disable iff (!rst_n)
        inReset_q |-> (oscEn.midRc && !oscEn.mainOsc && !oscEn.subOsc && !oscEn.lowRc && !oscEn.multiRc);
    endproperty
    a_reset_osc: assert property (p_reset_osc) else $error("Wrong oscillators in reset.");

    property p_wdog_sleep;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & enterStandby & ~sysReset & wdog_q[4:3] == 2'b01) |=> !wdog_q[5];
    endproperty
    a_wdog_sleep: assert property (p_wdog_sleep) else $error("Watchdog run bit not cleared.");

    property p_halt_mode;
        @(posedge clock) disable iff (!rst_n)
        (halt_q && !stop_q) |-> (mode == standby_pkg::MODE_HALT);
    endproperty
    a_halt_mode: assert property (p_halt_mode) else $error("Halt flag alone not decoded as halt.");

    property p_halt_cpu;
        @(posedge clock) disable iff (!rst_n)
        (mode != standby_pkg::MODE_NORMAL) |-> cpuStopped;
    endproperty
    a_halt_cpu: assert property (p_halt_cpu) else $error("CPU running in a standby mode.");

    property p_reset_flags;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & sysReset) |=> (!stop_q && !halt_q && !xtal_q && cpuInReset);
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("Reset did not clear mode flags.");

    property p_entry_now;
        @(posedge clock) disable iff (!rst_n)
        (wrPwr & pwdata[1] & ~sysReset) |=>
            (!oscEn.mainOsc && !oscEn.lowRc && !oscEn.midRc && !oscEn.multiRc && cpuStopped);
    endproperty
    a_entry_now: assert property (p_entry_now) else $error("Standby enables late after the write.");

    property p_exit_rc;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & stop_q & ~xtal_q & wake & ~wr & ~sysReset) |=>
            (slow_q[1] ? (oscEn.lowRc && !oscEn.midRc) : (oscEn.midRc == !slow_q[0]));
    endproperty
    a_exit_rc: assert property (p_exit_rc) else $error("Wrong RC oscillator after hold.");

    property p_hold_exit;
        @(posedge clock) disable iff (!rst_n)
        (clkEn & stop_q & ~xtal_q & wake & ~wr & ~sysReset) |=>
            (oscEn.mainOsc == osc_q[0] && oscEn.subOsc == osc_q[2] && !oscEn.multiRc);
    endproperty
    a_hold_exit: assert property (p_hold_exit) else $error("Main or sub enable not restored after hold.");

    property p_halt_keep;
        @(posedge clock) disable iff (!rst_n)
        (mode == standby_pkg::MODE_HALT && !inReset_q) |->
            (oscEn.mainOsc == osc_q[0] && oscEn.subOsc == osc_q[2] && oscEn.multiRc == multi_q[0]
             && oscEn.lowRc == (slow_q[1] | wdogLowRcReq));
    endproperty
    a_halt_keep: assert property (p_halt_keep) else $error("Oscillator changed in halt.");

    property p_xhold_run;
        @(posedge clock) disable iff (!rst_n)
        (mode == standby_pkg::MODE_XHOLD && !inReset_q) |->
            (!oscEn.mainOsc && !oscEn.lowRc && !oscEn.midRc && !oscEn.multiRc
             && oscEn.subOsc == osc_q[2] && baseTimerRun == osc_q[2]);
    endproperty
    a_xhold_run: assert property (p_xhold_run) else $error("Crystal hold clocks wrong.");
endmodule
`default_nettype wire

// ### standby_partner.sv
// Model of the CPU core and the wake sources beside the standby mode controller.
`default_nettype none
module standby_partner (
    input wire logic clock,
    input wire logic [5:0] wakeReq,
    input wire logic irqReq,
    input wire logic [3:0] irqDelay,
    output logic [5:0] wakeLines,
    output logic irqAccept
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q = 4'h0;
    logic pend_q = 1'b0;
    logic [5:0] wake_q = 6'h00;
    logic accept_q = 1'b0;
    assign wakeLines = wake_q;
    assign irqAccept = accept_q;
    always @(posedge clock) begin
        wake_q <= wakeReq;
        accept_q <= 1'b0;
        if (irqReq && !pend_q) begin
            pend_q <= 1'b1;
            wait_q <= irqDelay;
        end else if (pend_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else if (pend_q) begin
            accept_q <= 1'b1;
            pend_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### standby_mode_controller_tb.sv
// Self-checking testbench of the standby mode controller.
`default_nettype none
`define CHECK(g, e) begin nChecks++; if ((g) !== (e)) begin nErrors++; $display("MISMATCH %0t got %h expected %h", $time, g, e); end end
module standby_mode_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irqAccept, cpuStopped, cpuInReset, baseTimerRun, err, s;
    logic [2:0] rstSrc = 3'h0;
    logic lowReq = 1'b0;
    logic clkEn = 1'b1;
    logic irqReq = 1'b0;
    logic [3:0] irqDelay = 4'h0;
    logic [5:0] wakeReq = 6'h00;
    logic [5:0] wakeLines;
    logic [7:0] rd;
    standby_pkg::osc_en_t oscEn;
    standby_pkg::mode_t mode;
    int nErrors = 0;
    int nChecks = 0;
    int cycles = 0;
    standby_mode_controller i_standby_mode_controller (
        .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .externalClearPin(rstSrc[0]), .supplyDropDetector(rstSrc[1]), .wdogTrip(rstSrc[2]),
        .wdogLowRcReq(lowReq), .irqAccept(irqAccept), .baseTimerIrq(wakeLines[0]), .extIrqZero(wakeLines[1]),
        .extIrqOne(wakeLines[2]), .extIrqTwo(wakeLines[3]), .extIrqFour(wakeLines[4]), .port0Irq(wakeLines[5]),
        .oscEn(oscEn), .mode(mode), .cpuStopped(cpuStopped), .cpuInReset(cpuInReset), .baseTimerRun(baseTimerRun));
    standby_partner i_standby_partner (
        .clock(clock), .wakeReq(wakeReq), .irqReq(irqReq), .irqDelay(irqDelay),
        .wakeLines(wakeLines), .irqAccept(irqAccept));
    initial begin
        forever #12.5 clock = ~clock;
    end
    task automatic finalReport;
        $display("Checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            nErrors++;
            finalReport();
        end
    end
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        `CHECK(rd, e)
    endtask
    task automatic wake(input int i);
        @(posedge clock);
        wakeReq <= 6'h01 << i;
        repeat (2) @(posedge clock);
        wakeReq <= 6'h00;
        repeat (6) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic ack(input logic [3:0] dl);
        @(posedge clock);
        irqReq <= 1'b1;
        irqDelay <= dl;
        @(posedge clock);
        irqReq <= 1'b0;
        repeat (20) @(posedge clock);
        @(negedge clock);
    endtask
    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock);
        `CHECK(cpuInReset, 1'b1)
        `CHECK(oscEn, 5'b00010)
        @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        `CHECK(cpuInReset, 1'b0)
        `CHECK(mode, standby_pkg::MODE_NORMAL)
        acc(1'b1, 8'h00, 8'hF0);
        rdChk(8'h00, 8'hF8);
        rdChk(8'h14, 8'h00);
        `CHECK(err, 1'b1)
        acc(1'b1, 8'h08, 8'h05);
        acc(1'b1, 8'h10, 8'h28);
        acc(1'b1, 8'h00, 8'h01);
        @(negedge clock);
        `CHECK(mode, standby_pkg::MODE_HALT)
        `CHECK(cpuStopped, 1'b1)
        `CHECK(oscEn, 5'b11010)
        @(posedge clock);
        lowReq <= 1'b1;
        @(negedge clock);
        `CHECK(oscEn, 5'b11110)
        @(posedge clock);
        lowReq <= 1'b0;
        rdChk(8'h10, 8'h08);
        clkEn <= 1'b0;
        ack(4'h3);
        `CHECK(mode, standby_pkg::MODE_HALT)
        @(posedge clock);
        clkEn <= 1'b1;
        ack(4'h3);
        `CHECK(mode, standby_pkg::MODE_NORMAL)
        `CHECK(cpuStopped, 1'b0)
        for (int i = 1; i < 6; i++) begin
            s = i[0];
            acc(1'b1, 8'h04, {6'h00, s, 1'b0});
            acc(1'b1, 8'h08, 8'h37);
            acc(1'b1, 8'h0C, 8'h01);
            acc(1'b1, 8'h10, s ? 8'h38 : 8'h28);
            acc(1'b1, 8'h00, 8'h02);
            @(negedge clock);
            `CHECK(mode, standby_pkg::MODE_HOLD)
            `CHECK(oscEn, 5'b00000)
            `CHECK(baseTimerRun, 1'b0)
            rdChk(8'h00, 8'hFB);
            rdChk(8'h04, {6'h00, s, s});
            rdChk(8'h08, s ? 8'h07 : 8'h05);
            rdChk(8'h0C, 8'h00);
            rdChk(8'h10, s ? 8'h38 : 8'h08);
            if (i == 1) begin
                wake(0);
                `CHECK(mode, standby_pkg::MODE_HOLD)
            end
            wake(i);
            `CHECK(mode, standby_pkg::MODE_HALT)
            `CHECK(oscEn, s ? 5'b11100 : 5'b11010)
            rdChk(8'h00, 8'hF9);
            ack(4'(i * 3));
            `CHECK(mode, standby_pkg::MODE_NORMAL)
        end
        acc(1'b1, 8'h04, 8'h01);
        acc(1'b1, 8'h08, 8'h06);
        acc(1'b1, 8'h0C, 8'h00);
        acc(1'b1, 8'h10, 8'h28);
        acc(1'b1, 8'h00, 8'h06);
        @(negedge clock);
        `CHECK(mode, standby_pkg::MODE_XHOLD)
        `CHECK(oscEn, 5'b01000)
        `CHECK(baseTimerRun, 1'b1)
        rdChk(8'h04, 8'h01);
        rdChk(8'h08, 8'h06);
        rdChk(8'h0C, 8'h00);
        rdChk(8'h10, 8'h08);
        wake(0);
        `CHECK(mode, standby_pkg::MODE_HALT)
        rdChk(8'h00, 8'hFD);
        ack(4'h0);
        rdChk(8'h00, 8'hFC);
        acc(1'b1, 8'h00, 8'h00);
        rdChk(8'h00, 8'hF8);
        for (int k = 0; k < 3; k++) begin
            acc(1'b1, 8'h00, 8'h01);
            @(posedge clock);
            rstSrc <= 3'h1 << k;
            repeat (6) @(posedge clock);
            @(negedge clock);
            `CHECK(cpuInReset, 1'b1)
            `CHECK(oscEn, 5'b00010)
            @(posedge clock);
            rstSrc <= 3'h0;
            repeat (8) @(posedge clock);
            @(negedge clock);
            `CHECK(cpuInReset, 1'b0)
            `CHECK(mode, standby_pkg::MODE_NORMAL)
            rdChk(8'h10, k == 2 ? 8'h80 : 8'h00);
        end
        finalReport();
    end
endmodule
`default_nettype wire
